// ---- rtl/cal_calendar.sv ----
// Calendar counters: BCD day, month, year and weekday behind an AHB-Lite slave.
// Functional notes
// - Day units count 0-9, carry to tens.
// - Day tens count up to 2 or 3.
// - Month end: day becomes 01, month advances.
// - Month units count 0-9, carry to tens.
// - Month units carry sets month tens bit.
// - Year change: month becomes 01, year advances.
// - Year units count 0-9, carry to tens.
// - Year tens count 0-9 on units carry.
// - Weekday cycles 0-6 with day units.
// - Soft reset leaves calendar counters unchanged.
// - Counters need no defined power-on value.
// - Hour counter wrap supplies the day carry.
// - Hold stops counters; divider keeps running.
`timescale 1ns/1ns
`default_nettype none
module cal_calendar
   import cal_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        ce,
   input  wire logic        day_carry,
   input  wire logic        counter_hold_bit,
   input  wire logic        clock_soft_reset,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   output logic             carry_busy_flag
);

   typedef struct packed {
      logic [1:0] day_tens;
      logic [3:0] day_units;
      logic       month_tens_bit;
      logic [3:0] month_units;
      logic [3:0] year_tens;
      logic [3:0] year_units;
      logic [2:0] weekday_count;
      logic       hold_sw;
      logic       pending;
      logic [7:0] rdata;
   } cal_state_s;

   localparam cal_state_s CAL_STATE_RST = '{
      day_tens:       CAL_DAY_TENS_RST,
      day_units:      CAL_DAY_UNITS_RST,
      month_tens_bit: CAL_MONTH_TENS_RST,
      month_units:    CAL_MONTH_UNITS_RST,
      year_tens:      CAL_YEAR_RST,
      year_units:     CAL_YEAR_RST,
      weekday_count:  CAL_WEEKDAY_RST,
      hold_sw:        1'b0,
      pending:        1'b0,
      rdata:          8'h00
   };

   cal_state_s st_reg;
   cal_state_s st_next;
   logic       rd_take;
   logic       wr_take;
   cal_sel_e   rd_sel;
   cal_sel_e   wr_sel;
   logic [1:0] last_tens;
   logic [3:0] last_units;
   logic       hold;
   logic       adv;
   logic       at_last;
   logic       at_dec;
   logic [4:0] inc_day;
   logic [4:0] inc_month;
   logic [4:0] inc_yu;
   logic [4:0] inc_yt;
   logic [7:0] wbyte;

   // ----------------------------------------------------------------
   // Bus front end and month length
   // ----------------------------------------------------------------
   cal_bus_slave u_slave (
      .clk       (clk),
      .reset     (reset),
      .ce        (ce),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .rd_take   (rd_take),
      .rd_sel    (rd_sel),
      .wr_take   (wr_take),
      .wr_sel    (wr_sel)
   );

   cal_month_len u_len (
      .month_tens_bit (st_reg.month_tens_bit),
      .month_units    (st_reg.month_units),
      .year_tens      (st_reg.year_tens),
      .year_units     (st_reg.year_units),
      .last_tens      (last_tens),
      .last_units     (last_units)
   );

   // ----------------------------------------------------------------
   // Carry decode
   // ----------------------------------------------------------------
   // Only whole-word transfers are used, so hsize does not gate the write.
   assign wbyte   = hwdata[7:0];
   assign hold    = counter_hold_bit || st_reg.hold_sw;
   // A carry seen while held is kept and applied when the hold ends.
   assign adv     = ce && (day_carry || st_reg.pending) && !hold;
   assign at_last = (st_reg.day_tens == last_tens) && (st_reg.day_units == last_units);
   assign at_dec  = st_reg.month_tens_bit && (st_reg.month_units == 4'h2);
   assign inc_day   = cal_bcd_inc(st_reg.day_units);
   assign inc_month = cal_bcd_inc(st_reg.month_units);
   assign inc_yu    = cal_bcd_inc(st_reg.year_units);
   assign inc_yt    = cal_bcd_inc(st_reg.year_tens);
   assign hrdata          = {24'h00_0000, st_reg.rdata};
   assign carry_busy_flag = st_reg.pending;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      if (ce) begin
         // A carry arriving at a release keeps the pending carry set, so both are applied.
         st_next.pending = hold ? (st_reg.pending || day_carry)
                                : (st_reg.pending && day_carry);
         if (adv) begin
            if (st_reg.weekday_count >= CAL_WEEKDAY_LAST) begin
               st_next.weekday_count = CAL_WEEKDAY_RST;
            end else begin
               st_next.weekday_count = st_reg.weekday_count + 3'h1;
            end
            if (at_last) begin
               st_next.day_tens  = 2'h0;
               st_next.day_units = 4'h1;
               if (at_dec) begin
                  st_next.month_tens_bit = 1'b0;
                  st_next.month_units    = 4'h1;
                  st_next.year_units     = inc_yu[3:0];
                  if (inc_yu[4]) begin
                     st_next.year_tens = inc_yt[3:0];
                  end
               end else begin
                  st_next.month_units = inc_month[3:0];
                  if (inc_month[4]) begin
                     st_next.month_tens_bit = 1'b1;
                  end
               end
            end else begin
               st_next.day_units = inc_day[3:0];
               if (inc_day[4]) begin
                  st_next.day_tens = st_reg.day_tens + 2'h1;
               end
            end
         end
         // A software write wins over a carry in the same cycle.
         if (wr_take) begin
            case (wr_sel)
               CAL_SEL_DAY: begin
                  st_next.day_tens  = wbyte[CAL_DAY_TENS_LSB +: 2];
                  st_next.day_units = wbyte[3:0];
               end
               CAL_SEL_MONTH: begin
                  st_next.month_tens_bit = wbyte[CAL_MONTH_TENS_BIT];
                  st_next.month_units    = wbyte[3:0];
               end
               CAL_SEL_YEAR: begin
                  st_next.year_tens  = wbyte[CAL_YEAR_TENS_LSB +: 4];
                  st_next.year_units = wbyte[3:0];
               end
               CAL_SEL_WEEKDAY: begin
                  st_next.weekday_count = wbyte[2:0];
               end
               CAL_SEL_CONTROL: begin
                  st_next.hold_sw = wbyte[CAL_CTRL_HOLD_BIT];
               end
               default: begin
                  st_next.hold_sw = st_reg.hold_sw;
               end
            endcase
         end
         // Soft reset only touches control state; the counters run on.
         if (clock_soft_reset) begin
            st_next.hold_sw = 1'b0;
         end
         // Read data is taken from the next values so a read right after
         // a write returns the written value.
         if (rd_take) begin
            case (rd_sel)
               CAL_SEL_DAY: begin
                  st_next.rdata = {2'b00, st_next.day_tens, st_next.day_units};
               end
               CAL_SEL_MONTH: begin
                  st_next.rdata = {3'b000, st_next.month_tens_bit, st_next.month_units};
               end
               CAL_SEL_YEAR: begin
                  st_next.rdata = {st_next.year_tens, st_next.year_units};
               end
               CAL_SEL_WEEKDAY: begin
                  st_next.rdata = {5'b00000, st_next.weekday_count};
               end
               CAL_SEL_CONTROL: begin
                  st_next.rdata = 8'h00;
                  st_next.rdata[CAL_CTRL_HOLD_BIT]   = st_next.hold_sw;
                  st_next.rdata[CAL_CTRL_BUSY_BIT]   = st_next.pending;
                  st_next.rdata[CAL_CTRL_EXTHLD_BIT] = counter_hold_bit;
               end
               default: begin
                  st_next.rdata = 8'h00;
               end
            endcase
         end
      end
   end

   // Power-on values are a convenience only; software must set the date.
   always_ff @(posedge clk) begin
      if (reset) begin
         st_reg <= CAL_STATE_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence s_adv_nowr;
      adv && !wr_take;
   endsequence

   property p_day_units;
      (s_adv_nowr and (!at_last && st_reg.day_units == 4'h9))
      |=> (st_reg.day_units == 4'h0) && (st_reg.day_tens == $past(st_reg.day_tens) + 2'h1);
   endproperty
   a_day_units: assert property (p_day_units) else $error("day units did not wrap");

   property p_month_end;
      (s_adv_nowr and at_last)
      |=> (st_reg.day_tens == 2'h0) && (st_reg.day_units == 4'h1);
   endproperty
   a_month_end: assert property (p_month_end) else $error("month end did not set day 01");

   property p_sept;
      (s_adv_nowr and (at_last && !st_reg.month_tens_bit && st_reg.month_units == 4'h9))
      |=> st_reg.month_tens_bit && (st_reg.month_units == 4'h0);
   endproperty
   a_sept: assert property (p_sept) else $error("month 09 did not go to 10");

   property p_year_change;
      (s_adv_nowr and (at_last && at_dec))
      |=> !st_reg.month_tens_bit && (st_reg.month_units == 4'h1)
          && (st_reg.year_units != $past(st_reg.year_units));
   endproperty
   a_year_change: assert property (p_year_change) else $error("december end wrong");

   property p_year_roll;
      (s_adv_nowr and (at_last && at_dec && st_reg.year_tens == 4'h9
                       && st_reg.year_units == 4'h9))
      |=> (st_reg.year_tens == 4'h0) && (st_reg.year_units == 4'h0);
   endproperty
   a_year_roll: assert property (p_year_roll) else $error("year 99 did not roll to 00");

   property p_weekday;
      s_adv_nowr |=> (st_reg.weekday_count ==
         (($past(st_reg.weekday_count) >= 3'h6) ? 3'h0 : $past(st_reg.weekday_count) + 3'h1));
   endproperty
   a_weekday: assert property (p_weekday) else $error("weekday did not step");

   property p_leap;
      (s_adv_nowr and (!st_reg.month_tens_bit && st_reg.month_units == 4'h2
                       && st_reg.day_tens == 2'h2 && st_reg.day_units == 4'h8
                       && st_reg.year_tens == 4'h2 && st_reg.year_units == 4'h4))
      |=> (st_reg.day_units == 4'h9) && (st_reg.month_units == 4'h2);
   endproperty
   a_leap: assert property (p_leap) else $error("leap february ended on 28");

   property p_hold;
      (ce && hold && !wr_take) |=> $stable({st_reg.day_tens, st_reg.day_units,
         st_reg.month_tens_bit, st_reg.month_units, st_reg.year_tens, st_reg.year_units,
         st_reg.weekday_count});
   endproperty
   a_hold: assert property (p_hold) else $error("counters moved while held");

   property p_soft_reset;
      (clock_soft_reset && !adv && !wr_take) |=> $stable(st_reg.day_units)
         && $stable(st_reg.month_units) && $stable(st_reg.year_units)
         && $stable(st_reg.weekday_count);
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset changed counters");

   property p_upper_zero;
      (rd_take && rd_sel == CAL_SEL_WEEKDAY) |=> (hrdata == {29'h0, st_reg.weekday_count});
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("weekday upper bits not zero");

   property p_carry_kept;
      (ce && day_carry && hold) |=> carry_busy_flag;
   endproperty
   a_carry_kept: assert property (p_carry_kept) else $error("held carry was lost");

   property p_month_step;
      (s_adv_nowr and (at_last && !at_dec && st_reg.month_units < 4'h9))
      |=> (st_reg.month_units == $past(st_reg.month_units) + 4'h1)
          && (st_reg.month_tens_bit == $past(st_reg.month_tens_bit));
   endproperty
   a_month_step: assert property (p_month_step) else $error("month did not step by one");

   property p_release;
      (ce && !hold && st_reg.pending && !wr_take)
      |=> (st_reg.weekday_count != $past(st_reg.weekday_count));
   endproperty
   a_release: assert property (p_release) else $error("pending carry not applied");

   property p_wd_write;
      (wr_take && wr_sel == CAL_SEL_WEEKDAY)
      |=> (st_reg.weekday_count == $past(hwdata[2:0]));
   endproperty
   a_wd_write: assert property (p_wd_write) else $error("weekday write did not land");

   property p_day_write;
      (wr_take && wr_sel == CAL_SEL_DAY)
      |=> ({st_reg.day_tens, st_reg.day_units} == $past(hwdata[5:0]));
   endproperty
   a_day_write: assert property (p_day_write) else $error("day write did not land");

endmodule
`default_nettype wire

// ---- shared/cal_pkg.sv ----
// Shared constants, types and helpers for the calendar counter block.
package cal_pkg;

   // ----------------------------------------------------------------
   // Register indices; the byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [29:0] CAL_IDX_DAY     = 30'h0000_5147;
   localparam logic [29:0] CAL_IDX_MONTH   = 30'h0000_5148;
   localparam logic [29:0] CAL_IDX_YEAR    = 30'h0000_5149;
   localparam logic [29:0] CAL_IDX_WEEKDAY = 30'h0000_514a;
   localparam logic [29:0] CAL_IDX_CONTROL = 30'h0000_514b;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CAL_DAY_TENS_LSB    = 4;
   localparam int CAL_MONTH_TENS_BIT  = 4;
   localparam int CAL_YEAR_TENS_LSB   = 4;
   localparam int CAL_CTRL_HOLD_BIT   = 0;
   localparam int CAL_CTRL_BUSY_BIT   = 1;
   localparam int CAL_CTRL_EXTHLD_BIT = 2;

   // ----------------------------------------------------------------
   // Reset values and digit limits
   // ----------------------------------------------------------------
   localparam logic [1:0] CAL_DAY_TENS_RST    = 2'h0;
   localparam logic [3:0] CAL_DAY_UNITS_RST   = 4'h1;
   localparam logic       CAL_MONTH_TENS_RST  = 1'b0;
   localparam logic [3:0] CAL_MONTH_UNITS_RST = 4'h1;
   localparam logic [3:0] CAL_YEAR_RST        = 4'h0;
   localparam logic [2:0] CAL_WEEKDAY_RST     = 3'h0;
   localparam logic [2:0] CAL_WEEKDAY_LAST    = 3'h6;
   localparam logic [3:0] CAL_BCD_LAST        = 4'h9;

   typedef enum logic [2:0] {
      CAL_SEL_NONE,
      CAL_SEL_DAY,
      CAL_SEL_MONTH,
      CAL_SEL_YEAR,
      CAL_SEL_WEEKDAY,
      CAL_SEL_CONTROL
   } cal_sel_e;

   // Returns the wrap flag above the next BCD digit.
   function automatic logic [4:0] cal_bcd_inc(input logic [3:0] d);
      if (d >= CAL_BCD_LAST) begin
         return {1'b1, 4'h0};
      end
      return {1'b0, d + 4'h1};
   endfunction

   function automatic cal_sel_e cal_decode(input logic [31:0] addr);
      if (addr == {CAL_IDX_DAY, 2'b00}) begin
         return CAL_SEL_DAY;
      end else if (addr == {CAL_IDX_MONTH, 2'b00}) begin
         return CAL_SEL_MONTH;
      end else if (addr == {CAL_IDX_YEAR, 2'b00}) begin
         return CAL_SEL_YEAR;
      end else if (addr == {CAL_IDX_WEEKDAY, 2'b00}) begin
         return CAL_SEL_WEEKDAY;
      end else if (addr == {CAL_IDX_CONTROL, 2'b00}) begin
         return CAL_SEL_CONTROL;
      end
      return CAL_SEL_NONE;
   endfunction

endpackage

// ---- rtl/cal_month_len.sv ----
// Last day of the current month, leap years included.
`timescale 1ns/1ns
`default_nettype none
module cal_month_len
   import cal_pkg::*;
(
   input  wire logic       month_tens_bit,
   input  wire logic [3:0] month_units,
   input  wire logic [3:0] year_tens,
   input  wire logic [3:0] year_units,
   output logic      [1:0] last_tens,
   output logic      [3:0] last_units
);

   logic leap;

   always_comb begin
      // A two-digit year divisible by four: even tens with 0/4/8, odd tens with 2/6.
      if (year_tens[0] == 1'b0) begin
         leap = (year_units == 4'h0) || (year_units == 4'h4) || (year_units == 4'h8);
      end else begin
         leap = (year_units == 4'h2) || (year_units == 4'h6);
      end
      last_tens  = 2'h3;
      last_units = 4'h1;
      if (month_tens_bit) begin
         if (month_units == 4'h1) begin
            last_units = 4'h0;
         end
      end else if (month_units == 4'h2) begin
         last_tens  = 2'h2;
         last_units = leap ? 4'h9 : 4'h8;
      end else if ((month_units == 4'h4) || (month_units == 4'h6) || (month_units == 4'h9)) begin
         last_units = 4'h0;
      end
   end

endmodule
`default_nettype wire

// ---- rtl/cal_bus_slave.sv ----
// AHB-Lite slave front end: address phase decode and data phase tracking.
`timescale 1ns/1ns
`default_nettype none
module cal_bus_slave
   import cal_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        ce,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic             rd_take,
   output cal_sel_e         rd_sel,
   output logic             wr_take,
   output cal_sel_e         wr_sel
);

   typedef struct packed {
      logic     dvalid;
      logic     dwrite;
      cal_sel_e dsel;
   } cal_slave_s;

   cal_slave_s st_reg;
   cal_slave_s st_next;
   logic       addr_phase;

   // ----------------------------------------------------------------
   // Handshake
   // ----------------------------------------------------------------
   // Zero wait states; a frozen block holds the bus off instead.
   assign hreadyout  = ce;
   assign hresp      = 1'b0;
   assign addr_phase = hsel && htrans[1] && hready && ce;
   assign rd_take    = addr_phase && !hwrite;
   assign rd_sel     = cal_decode(haddr);
   assign wr_take    = st_reg.dvalid && st_reg.dwrite && ce;
   assign wr_sel     = st_reg.dsel;

   always_comb begin
      st_next = st_reg;
      if (ce) begin
         st_next.dvalid = addr_phase;
         st_next.dwrite = hwrite;
         st_next.dsel   = cal_decode(haddr);
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_reg <= '{dvalid: 1'b0, dwrite: 1'b0, dsel: CAL_SEL_NONE};
      end else begin
         st_reg <= st_next;
      end
   end

endmodule
`default_nettype wire

// ---- sim/rtc_calendar_counters_bench.sv ----
// Self-checking bench for the calendar counter block.
`timescale 1ns/1ns
`default_nettype none
module rtc_calendar_counters_bench
   import cal_pkg::*;
;
   logic        clk;
   logic        reset;
   logic        ce;
   logic        day_carry;
   logic        counter_hold_bit;
   logic        clock_soft_reset;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        carry_busy_flag;
   logic [31:0] rd;
   int          n_mismatch;
   int          tests_run;

   // Each row: day, month, year, weekday before one carry, then the same after it.
   logic [63:0] rows [14] = '{
      64'h09010000_10010001, 64'h28020102_01030103, 64'h28022403_29022404,
      64'h29020404_01030405, 64'h30042305_01052306, 64'h30012306_31012300,
      64'h30092300_01102301, 64'h31129906_01010000, 64'h31120901_01011002,
      64'h19110507_20110500, 64'h31100001_01110002, 64'h28020002_29020003,
      64'h30061903_01071904, 64'h29012104_30012105};

   cal_calendar u_dut (
      .clk             (clk),
      .reset           (reset),
      .ce              (ce),
      .day_carry       (day_carry),
      .counter_hold_bit(counter_hold_bit),
      .clock_soft_reset(clock_soft_reset),
      .hsel            (hsel),
      .haddr           (haddr),
      .htrans          (htrans),
      .hwrite          (hwrite),
      .hsize           (hsize),
      .hwdata          (hwdata),
      .hready          (hreadyout),
      .hreadyout       (hreadyout),
      .hresp           (hresp),
      .hrdata          (hrdata),
      .carry_busy_flag (carry_busy_flag)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Bus and comparison tasks
   // ----------------------------------------------------------------
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Entered just after a rising edge; leaves just after the data phase edge.
   task automatic bus_op(input logic wr, input logic [29:0] idx, input logic [7:0] wd);
      hsel   <= 1'b1;
      haddr  <= {idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= wr;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'ha5a5a5, wd};
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
      check({31'h0, hresp}, 32'h0);
   endtask

   task automatic wr(input logic [29:0] idx, input logic [7:0] d);
      bus_op(1'b1, idx, d);
   endtask

   task automatic rd_chk(input logic [29:0] idx, input logic [7:0] exp);
      bus_op(1'b0, idx, 8'h00);
      check(rd, {24'h0, exp});
   endtask

   task automatic set_date(input logic [31:0] v);
      wr(CAL_IDX_DAY, v[31:24]);
      wr(CAL_IDX_MONTH, v[23:16]);
      wr(CAL_IDX_YEAR, v[15:8]);
      wr(CAL_IDX_WEEKDAY, v[7:0]);
   endtask

   task automatic pulse_carry();
      day_carry <= 1'b1;
      @(posedge clk);
      day_carry <= 1'b0;
      @(posedge clk);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      reset            = 1'b1;
      ce               = 1'b1;
      day_carry        = 1'b0;
      counter_hold_bit = 1'b0;
      clock_soft_reset = 1'b0;
      hsel             = 1'b0;
      haddr            = 32'h0;
      htrans           = 2'h0;
      hwrite           = 1'b0;
      hsize            = 3'h2;
      hwdata           = 32'h0;
      n_mismatch       = 0;
      tests_run        = 0;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rd_chk(CAL_IDX_DAY, 8'h01);
      rd_chk(CAL_IDX_MONTH, 8'h01);
      foreach (rows[i]) begin
         set_date(rows[i][63:32]);
         pulse_carry();
         rd_chk(CAL_IDX_DAY, rows[i][31:24]);
         rd_chk(CAL_IDX_MONTH, rows[i][23:16]);
         rd_chk(CAL_IDX_YEAR, rows[i][15:8]);
         rd_chk(CAL_IDX_WEEKDAY, rows[i][7:0]);
      end
      // Reserved bits read zero even right after a write of all ones.
      wr(CAL_IDX_DAY, 8'hff);
      rd_chk(CAL_IDX_DAY, 8'h3f);
      wr(CAL_IDX_MONTH, 8'hff);
      rd_chk(CAL_IDX_MONTH, 8'h1f);
      wr(CAL_IDX_WEEKDAY, 8'hff);
      rd_chk(CAL_IDX_WEEKDAY, 8'h07);
      rd_chk(30'h0000_5150, 8'h00);
      // Two carries during an external hold merge into one at release.
      set_date(32'h05032402);
      counter_hold_bit <= 1'b1;
      @(posedge clk);
      pulse_carry();
      pulse_carry();
      rd_chk(CAL_IDX_DAY, 8'h05);
      check({31'h0, carry_busy_flag}, 32'h1);
      rd_chk(CAL_IDX_CONTROL, 8'h06);
      counter_hold_bit <= 1'b0;
      repeat (2) @(posedge clk);
      rd_chk(CAL_IDX_DAY, 8'h06);
      check({31'h0, carry_busy_flag}, 32'h0);
      // Software hold, then a soft reset that releases the held carry without resetting the counters.
      wr(CAL_IDX_CONTROL, 8'h01);
      pulse_carry();
      rd_chk(CAL_IDX_DAY, 8'h06);
      rd_chk(CAL_IDX_CONTROL, 8'h03);
      clock_soft_reset <= 1'b1;
      @(posedge clk);
      clock_soft_reset <= 1'b0;
      repeat (2) @(posedge clk);
      rd_chk(CAL_IDX_DAY, 8'h07);
      rd_chk(CAL_IDX_MONTH, 8'h03);
      rd_chk(CAL_IDX_YEAR, 8'h24);
      rd_chk(CAL_IDX_WEEKDAY, 8'h04);
      rd_chk(CAL_IDX_CONTROL, 8'h00);
      // A carry while the clock enable is low is not counted.
      ce <= 1'b0;
      @(posedge clk);
      check({31'h0, hreadyout}, 32'h0);
      pulse_carry();
      ce <= 1'b1;
      @(posedge clk);
      rd_chk(CAL_IDX_DAY, 8'h07);
      // Second reset in mid-run.
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rd_chk(CAL_IDX_YEAR, 8'h00);
      summarize();
   end

   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      summarize();
   end
endmodule
`default_nettype wire
